// File: verilog/sasq_regs.svh
// Register indices, field positions, reset values and timing counts of the ADC sequencer.
`ifndef SASQ_REGS_SVH
`define SASQ_REGS_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define SASQ_IDX_CTL1    6'h1c
`define SASQ_IDX_CTL2    6'h1d
`define SASQ_IDX_RES_LO  6'h1e
`define SASQ_IDX_RES_HI  6'h1f

// ----------------------------------------------------------------
// Reset values and fields
// ----------------------------------------------------------------
`define SASQ_CTL1_RST    8'h10
`define SASQ_CTL2_RST    6'h10
`define SASQ_C1_START    7
`define SASQ_C1_MODE     6:5
`define SASQ_C1_ANALOG_INPUT_DISABLE    4
`define SASQ_C1_CHAN     3:0
`define SASQ_C2_LADDER   5
`define SASQ_C2_BITS     5:0
`define SASQ_C2_TIME     3:1

// ----------------------------------------------------------------
// Conversion times in high_freq_clock cycles, pacing step constants and SAR first trial code
// ----------------------------------------------------------------
`define SASQ_T_39        11'h027
`define SASQ_T_78        11'h04e
`define SASQ_T_156       11'h09c
`define SASQ_T_312       11'h138
`define SASQ_T_624       11'h270
`define SASQ_T_1248      11'h4e0
`define SASQ_STEP_INC    11'h00a
`define SASQ_STEP_LAST   4'h9
`define SASQ_SAR_MSB     10'h200

`endif

// File: verilog/sasq_pkg.sv
// Types shared by the ADC sequencer modules.
`default_nettype none
package sasq_pkg;
  typedef enum logic [1:0] {
    MODE_OFF    = 2'h0,
    MODE_SOFT   = 2'h1,
    MODE_RSVD   = 2'h2,
    MODE_REPEAT = 2'h3
  } sasq_mode_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h1,
    ST_CONV = 2'h2
  } sasq_state_t;
endpackage : sasq_pkg
`default_nettype wire

// File: verilog/sasq_conv_if.sv
// Signals between the sequencer control, the pacing timer and the SAR register.
`default_nettype none
interface sasq_conv_if;
  logic        start;
  logic        abort;
  logic [10:0] cycles;
  logic        step;
  logic        last;
  logic        cmp;
  logic [9:0]  trial;
  logic [9:0]  final_code;

  modport ctl  (output start, abort, cycles, cmp,
                input  step, last, trial, final_code);
  modport pace (input  start, abort, cycles,
                output step, last);
  modport sar  (input  start, step, cmp,
                output trial, final_code);
endinterface : sasq_conv_if
`default_nettype wire

// File: verilog/sasq_pace.sv
// Spreads ten SAR bit decisions evenly over the selected conversion time.
`include "sasq_regs.svh"
`default_nettype none
module sasq_pace (
  input  wire logic i_clk,
  input  wire logic i_rstn,
  sasq_conv_if.pace cv
);
  logic        active;
  logic [10:0] acc;
  logic [3:0]  steps;
  logic [10:0] sum;
  logic        hit;

  // An accumulator keeps the slices within one cycle of each other even when the time is not a multiple of ten.
  assign sum     = acc + `SASQ_STEP_INC;
  assign hit     = (sum >= cv.cycles);
  assign cv.step = active && hit && !cv.abort;
  assign cv.last = cv.step && (steps == `SASQ_STEP_LAST);

  always_ff @(posedge i_clk) begin
    if (!i_rstn || cv.abort) begin
      active <= 1'b0;
      acc    <= 11'h000;
      steps  <= 4'h0;
    end else if (cv.start) begin
      active <= 1'b1;
      acc    <= 11'h000;
      steps  <= 4'h0;
    end else if (active) begin
      acc    <= hit ? sum - cv.cycles : sum;
      steps  <= hit ? steps + 4'h1 : steps;
      active <= !cv.last;
    end
  end
endmodule : sasq_pace
`default_nettype wire

// File: verilog/sasq_sar.sv
// Successive-approximation register, most significant bit first.
`include "sasq_regs.svh"
`default_nettype none
module sasq_sar (
  input  wire logic i_clk,
  input  wire logic i_rstn,
  sasq_conv_if.sar  cv
);
  logic [9:0] code;
  logic [9:0] mask;
  logic [9:0] next_code;

  // A low comparator answer means the trial level was too high: drop that bit.
  assign next_code     = cv.cmp ? code : (code & ~mask);
  assign cv.final_code = next_code;
  assign cv.trial      = code;

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      code <= 10'h000;
      mask <= 10'h000;
    end else if (cv.start) begin
      code <= `SASQ_SAR_MSB;
      mask <= `SASQ_SAR_MSB;
    end else if (cv.step) begin
      code <= next_code | (mask >> 1);
      mask <= mask >> 1;
    end
  end
endmodule : sasq_sar
`default_nettype wire

// File: verilog/sasq_top.sv
// APB register file and conversion sequencer of the 10-bit SAR ADC.
//
// Contract
// R1: start bit self-clears once conversion begins; reads back zero.
// R2: mode 00 off, 01 software start, 10 reserved, 11 repeat.
// R3: analog input control bit zero enables inputs, one disables.
// R4: channel field selects input 0 to 15 in binary order.
// R5: software changes channel only while busy flag is zero.
// R6: software does not restart while busy; waits for end flag.
// R7: low-power entry resets both control registers and blocks writes.
// R8: time code selects 39..1248 cycles; 001 and 111 reserved.
// R9: ladder connected only during conversion, or always.
// R10: software writes zero to bit 0, one to bit 4.
// R11: top two bits of second control register are don't-care.
// R12: software avoids inhibited conversion times for its clock.
// R13: result 9..2 high register; 1..0, end, busy low register.
// R14: reading high result clears end flag.
// R15: busy set at start, cleared at end or low-power entry.
// R16: completion stores result, sets end flag, raises interrupt together.
// R17: repeat mode restarts right after each completion.
// R18: writing mode 00 halts at once; partial value is dropped.
// R19: new start clears end flag; old result stays until done.
// R20: four low bits of low result register carry no data.
// R21: software start runs exactly one conversion, then idles.
// R22: low-power entry aborts, clears results, no automatic restart.
// R23: cycle counter times conversion, one SAR bit per slice.
// R24: completion interrupt is one pulse per conversion.
`include "sasq_regs.svh"
`default_nettype none
module sasq_top (
  input  wire logic        i_clk,
  input  wire logic        i_rstn,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output var  logic [31:0] o_prdata,
  output      logic        o_pready,
  output      logic        o_pslverr,
  input  wire logic        i_low_power,
  input  wire logic        i_cmp,
  output      logic [9:0]  o_dac_code,
  output      logic [3:0]  o_channel,
  output      logic        o_ain_disable,
  output      logic        o_ladder_on,
  output      logic        o_conv_active,
  output var  logic        o_conv_done_irq
);

  // ----------------------------------------------------------------
  // Time code decode
  // ----------------------------------------------------------------
  function automatic logic [10:0] sasq_tsel(input logic [2:0] code);
    case (code)
      3'h0:    sasq_tsel = `SASQ_T_39;
      3'h2:    sasq_tsel = `SASQ_T_78;
      3'h3:    sasq_tsel = `SASQ_T_156;
      3'h4:    sasq_tsel = `SASQ_T_312;
      3'h5:    sasq_tsel = `SASQ_T_624;
      3'h6:    sasq_tsel = `SASQ_T_1248;
      // Reserved codes fall back to the longest, most accurate time.
      default: sasq_tsel = `SASQ_T_1248;
    endcase
  endfunction : sasq_tsel

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  sasq_pkg::sasq_mode_t  mode;
  sasq_pkg::sasq_state_t state;
  sasq_pkg::sasq_state_t next_state;
  sasq_pkg::sasq_mode_t  wmode;
  logic       ain_dis;
  logic [3:0] chan;
  logic [5:0] ctl2;
  logic [7:0] res_hi;
  logic [1:0] res_lo;
  logic       eoc;
  logic       irq;

  sasq_conv_if cv ();

  // Initial value of the first control register, taken apart by field; only the start bit 7 is dropped.
  localparam logic [7:0] ctl1_init = `SASQ_CTL1_RST;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  logic [5:0]  idx;
  logic        aligned;
  logic        hit_c1;
  logic        hit_c2;
  logic        hit_rl;
  logic        hit_rh;
  logic        hit;
  logic        access;
  logic        wr_c1;
  logic        wr_c2;
  logic        rd_rh;
  logic [7:0]  rd_c1;
  logic [7:0]  rd_c2;
  logic [7:0]  rd_rl;
  logic [7:0]  next_rdata;

  assign idx     = i_paddr[7:2];
  assign aligned = (i_paddr[1:0] == 2'h0);
  assign hit_c1  = aligned && (idx == `SASQ_IDX_CTL1);
  assign hit_c2  = aligned && (idx == `SASQ_IDX_CTL2);
  assign hit_rl  = aligned && (idx == `SASQ_IDX_RES_LO);
  assign hit_rh  = aligned && (idx == `SASQ_IDX_RES_HI);
  assign hit     = hit_c1 || hit_c2 || hit_rl || hit_rh;
  assign access  = i_psel && i_penable;

  // Writes are ignored while the chip sits in a low-power mode.
  assign wr_c1 = access && i_pwrite && hit_c1 && !i_low_power; // [R7]
  assign wr_c2 = access && i_pwrite && hit_c2 && !i_low_power; // [R7]
  assign rd_rh = access && !i_pwrite && hit_rh;
  assign wmode = sasq_pkg::sasq_mode_t'(i_pwdata[`SASQ_C1_MODE]);

  // The start bit is never stored, so it always reads back as zero.
  assign rd_c1 = {1'b0, mode, ain_dis, chan}; // [R1]
  // Top two bits are don't-care and simply read as zero.
  assign rd_c2 = {2'h0, ctl2}; // [R11]
  // Unused low nibble reads as zero.
  assign rd_rl = {res_lo, eoc, o_conv_active, 4'h0}; // [R13] [R20]

  assign next_rdata = hit_c1 ? rd_c1 :
                      hit_c2 ? rd_c2 :
                      hit_rl ? rd_rl :
                      hit_rh ? res_hi : 8'h00;

  assign o_pready  = 1'b1;
  assign o_pslverr = access && !hit;

  // Read data is captured in the setup phase and stands through the access phase.
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      o_prdata <= 32'h0000_0000;
    end else if (i_psel && !i_penable) begin
      o_prdata <= {24'h00_0000, next_rdata};
    end
  end

  // ----------------------------------------------------------------
  // Sequencing
  // ----------------------------------------------------------------
  logic busy;
  logic start_acc;
  logic restart;
  logic abort;

  assign busy = (state == sasq_pkg::ST_CONV);

  // Mode 10 is reserved and, like off, starts no conversion; unlike off, it does not halt one in progress.
  assign start_acc = wr_c1 && i_pwdata[`SASQ_C1_START] && !busy &&
                     (wmode == sasq_pkg::MODE_SOFT ||
                      wmode == sasq_pkg::MODE_REPEAT); // [R2] [R21]
  assign restart   = cv.last && (mode == sasq_pkg::MODE_REPEAT); // [R17]
  assign abort     = i_low_power ||
                     (wr_c1 && wmode == sasq_pkg::MODE_OFF); // [R18] [R22]

  assign cv.start  = start_acc || restart;
  assign cv.abort  = abort;
  assign cv.cycles = sasq_tsel(ctl2[`SASQ_C2_TIME]); // [R8] [R23]
  assign cv.cmp    = i_cmp;

  always_comb begin
    next_state = state;
    case (state)
      sasq_pkg::ST_IDLE: begin
        if (start_acc) begin
          next_state = sasq_pkg::ST_CONV; // [R15]
        end
      end
      sasq_pkg::ST_CONV: begin
        if (abort) begin
          next_state = sasq_pkg::ST_IDLE; // [R18]
        end else if (cv.last && !restart) begin
          next_state = sasq_pkg::ST_IDLE; // [R15] [R21]
        end
      end
      default: next_state = sasq_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      state <= sasq_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  sasq_pace u_pace (
    .i_clk  (i_clk),
    .i_rstn (i_rstn),
    .cv     (cv.pace)
  );

  sasq_sar u_sar (
    .i_clk  (i_clk),
    .i_rstn (i_rstn),
    .cv     (cv.sar)
  );

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rstn || i_low_power) begin
      mode    <= sasq_pkg::sasq_mode_t'(ctl1_init[`SASQ_C1_MODE]); // [R7]
      ain_dis <= ctl1_init[`SASQ_C1_ANALOG_INPUT_DISABLE];
      chan    <= ctl1_init[`SASQ_C1_CHAN];
      ctl2    <= `SASQ_CTL2_RST; // [R7]
    end else begin
      if (wr_c1) begin
        mode    <= wmode;
        ain_dis <= i_pwdata[`SASQ_C1_ANALOG_INPUT_DISABLE];
        chan    <= i_pwdata[`SASQ_C1_CHAN];
      end
      if (wr_c2) begin
        ctl2 <= i_pwdata[`SASQ_C2_BITS];
      end
    end
  end

  // ----------------------------------------------------------------
  // Results, flags and interrupt
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rstn || i_low_power) begin
      res_hi <= 8'h00; // [R22]
      res_lo <= 2'h0;
    end else if (cv.last) begin
      // The pacing timer never reports a last step in an aborted cycle.
      res_hi <= cv.final_code[9:2]; // [R13] [R16]
      res_lo <= cv.final_code[1:0];
    end
  end

  // A completion in the same cycle as a clearing read keeps the flag set.
  always_ff @(posedge i_clk) begin
    if (!i_rstn || i_low_power) begin
      eoc <= 1'b0;
    end else if (cv.last) begin
      eoc <= 1'b1; // [R16]
    end else if (rd_rh || start_acc) begin
      eoc <= 1'b0; // [R14] [R19]
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn || i_low_power) begin
      irq <= 1'b0;
    end else begin
      irq <= cv.last; // [R16] [R24]
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign o_conv_done_irq = irq;
  assign o_conv_active   = busy;
  assign o_dac_code      = cv.trial;
  assign o_channel       = chan; // [R4]
  assign o_ain_disable   = ain_dis; // [R3]
  assign o_ladder_on     = ctl2[`SASQ_C2_LADDER] || busy; // [R9]

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [10:0] len_cnt;

  always_ff @(posedge i_clk) begin
    if (!i_rstn || cv.start) begin
      len_cnt <= 11'h000;
    end else if (busy) begin
      len_cnt <= len_cnt + 11'h001;
    end
  end

  AST_START_CLR: assert property (@(posedge i_clk) disable iff (!i_rstn) // [R1]
    start_acc |=> busy && !rd_c1[7])
    else $error("start bit not cleared or conversion not begun");

  AST_MODE_OK: assert property (@(posedge i_clk) disable iff (!i_rstn) // [R2]
    busy |-> (mode == sasq_pkg::MODE_SOFT || mode == sasq_pkg::MODE_REPEAT))
    else $error("converting while mode is off or reserved");

  AST_LP_INIT: assert property (@(posedge i_clk) disable iff (!i_rstn) // [R7]
    i_low_power |=> o_ain_disable && mode == sasq_pkg::MODE_OFF && ctl2 == `SASQ_CTL2_RST)
    else $error("control registers not initialised in low power");

  AST_CONV_LEN: assert property (@(posedge i_clk) disable iff (!i_rstn) // [R8]
    cv.last |-> len_cnt == cv.cycles - 11'h001)
    else $error("conversion length differs from selected time");

  AST_DONE: assert property (@(posedge i_clk) disable iff (!i_rstn) // [R16]
    cv.last && !i_low_power |=> eoc && irq && res_hi == $past(cv.final_code[9:2]))
    else $error("completion did not store result with flag and interrupt");

  AST_RD_CLR: assert property (@(posedge i_clk) disable iff (!i_rstn) // [R14]
    rd_rh && !cv.last |=> !eoc)
    else $error("end flag survived read of high result");

  AST_LP_BUSY: assert property (@(posedge i_clk) disable iff (!i_rstn) // [R15]
    i_low_power |=> !busy && res_hi == 8'h00)
    else $error("low power left busy set or results intact");

  AST_REPEAT: assert property (@(posedge i_clk) disable iff (!i_rstn) // [R17]
    restart && !abort |=> busy ##1 busy)
    else $error("repeat mode did not restart");

  AST_SINGLE: assert property (@(posedge i_clk) disable iff (!i_rstn) // [R21]
    cv.last && mode == sasq_pkg::MODE_SOFT |=> !busy)
    else $error("software start ran more than one conversion");

  AST_HALT: assert property (@(posedge i_clk) disable iff (!i_rstn) // [R18]
    busy && abort && !i_low_power |=> !busy && $stable(res_hi) && !irq)
    else $error("halt did not stop at once or stored a partial value");

  AST_KEEP: assert property (@(posedge i_clk) disable iff (!i_rstn) // [R19]
    start_acc |=> !eoc && $stable(res_hi))
    else $error("new start did not clear flag or lost old result");

  AST_IRQ_PULSE: assert property (@(posedge i_clk) disable iff (!i_rstn) // [R24]
    irq |=> !irq)
    else $error("interrupt longer than one cycle");

  AST_BUSY_RISE: assert property (@(posedge i_clk) disable iff (!i_rstn) // [R15]
    !busy && !start_acc |=> !busy)
    else $error("busy flag rose without an accepted start");

  AST_RES_HOLD: assert property (@(posedge i_clk) disable iff (!i_rstn) // [R19]
    !cv.last && !i_low_power |=> $stable(res_hi) && $stable(res_lo))
    else $error("result changed without a completed conversion");

  AST_SAR_FIRST: assert property (@(posedge i_clk) disable iff (!i_rstn) // [R23]
    cv.start |=> o_dac_code == `SASQ_SAR_MSB)
    else $error("conversion did not begin with the top trial bit");

endmodule : sasq_top
`default_nettype wire

// File: dv/sasq_analog_model.sv
// Behavioural analog front end of the ADC sequencer: input sources, ladder and comparator.
`default_nettype none
module sasq_analog_model (
  input  wire logic       i_clk,
  input  wire logic [9:0] i_dac_code,
  input  wire logic [3:0] i_channel,
  input  wire logic       i_ain_disable,
  input  wire logic       i_ladder_on,
  output var  logic       o_cmp
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Input levels and comparator
  // ----------------------------------------------------------------
  logic [9:0] level;
  logic       junk = 1'b0;
  // A disabled input reads as ground; every channel gets its own code.
  assign level = i_ain_disable ? 10'h000 : {i_channel, 2'h1, i_channel};
  // A disconnected ladder gives no valid answer, so the output toggles to expose misuse.
  always @(posedge i_clk) junk <= ~junk;
  always_comb o_cmp = i_ladder_on ? (level >= i_dac_code) : junk;
endmodule : sasq_analog_model
`default_nettype wire

// File: dv/sar_adc_sequencer_tb_top.sv
// Self-checking testbench of the ADC sequencer, driven over APB.
`include "sasq_regs.svh"
`default_nettype none
module sar_adc_sequencer_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] A_C1 = {`SASQ_IDX_CTL1, 2'b00};
  localparam logic [7:0] A_C2 = {`SASQ_IDX_CTL2, 2'b00};
  localparam logic [7:0] A_RL = {`SASQ_IDX_RES_LO, 2'b00};
  localparam logic [7:0] A_RH = {`SASQ_IDX_RES_HI, 2'b00};
  logic        clk, rstn, psel, penable, pwrite, low_power, cmp;
  logic        pready, pslverr, ain_dis, ladder_on, active, irq;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [9:0]  dac;
  logic [3:0]  chan;
  logic [7:0]  r;
  logic        e;
  int          num_errors, check_count, n;
  logic [2:0]  tcode [8] = '{3'h0, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h1, 3'h7};
  int          tcyc  [8] = '{39, 78, 156, 312, 624, 1248, 1248, 1248};

  sasq_top u_dut (.i_clk(clk), .i_rstn(rstn), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_low_power(low_power), .i_cmp(cmp),
    .o_dac_code(dac), .o_channel(chan), .o_ain_disable(ain_dis), .o_ladder_on(ladder_on),
    .o_conv_active(active), .o_conv_done_irq(irq));
  sasq_analog_model u_analog (.i_clk(clk), .i_dac_code(dac), .i_channel(chan),
    .i_ain_disable(ain_dis), .i_ladder_on(ladder_on), .o_cmp(cmp));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic give_verdict();
    if (num_errors == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] wd);
    int k;
    k = 0;
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= {24'h000000, wd};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 100);
    r = prdata[7:0];
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (k >= 100) begin
      num_errors++;
      give_verdict();
    end
  endtask : apb

  // Counts cycles up to the next completion pulse; a missing pulse ends the run.
  task automatic wait_irq();
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (irq !== 1'b1 && n < 1300);
    if (n >= 1300) begin
      num_errors++;
      give_verdict();
    end
  endtask : wait_irq

  task automatic quiet(input int cyc);
    int hits;
    hits = 0;
    repeat (cyc) begin
      @(posedge clk);
      #1;
      hits += int'(irq | active);
    end
    chk(16'(hits), 16'h0000);
  endtask : quiet

  // Expected result halves for the per-channel level that the analog model presents.
  function automatic logic [7:0] code_hi(input logic [3:0] ch);
    return {ch, 2'b01, ch[3:2]};
  endfunction : code_hi

  function automatic logic [1:0] code_lo(input logic [3:0] ch);
    return ch[1:0];
  endfunction : code_lo

  task automatic convert(input logic [3:0] ch, input logic [2:0] tc, input int cyc);
    apb(1'b1, A_C2, {3'b001, tc, 1'b0} | 8'h10);
    apb(1'b1, A_C1, {3'b101, 1'b0, ch});
    #1;
    chk(active, 1'b1);
    chk(dac, 10'h200);
    chk(ladder_on, 1'b1);
    chk({ain_dis, chan}, {1'b0, ch});
    wait_irq();
    chk(16'(n), 16'(cyc));
    @(posedge clk);
    #1;
    chk({irq, active, ladder_on}, 3'b000);
    apb(1'b0, A_RL, 8'h00);
    chk(r & 8'hf0, {code_lo(ch), 2'b10, 4'h0});
    apb(1'b0, A_RH, 8'h00);
    chk(r, code_hi(ch));
    apb(1'b0, A_RL, 8'h00);
    chk(r[5], 1'b0);
    apb(1'b0, A_C1, 8'h00);
    chk(r, {3'b001, 1'b0, ch});
  endtask : convert

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    low_power = 1'b0;
    num_errors = 0;
    check_count = 0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    apb(1'b0, A_C1, 8'h00);
    chk({r, ain_dis}, {8'h10, 1'b1});
    apb(1'b0, A_C2, 8'h00);
    chk(r & 8'h3f, 8'h10);
    apb(1'b0, A_RL, 8'h00);
    chk(r & 8'hf0, 8'h00);
    apb(1'b1, A_RH, 8'hff);
    apb(1'b0, A_RH, 8'h00);
    chk(r, 8'h00);
    apb(1'b0, 8'h40, 8'h00);
    chk(e, 1'b1);
    for (int m = 0; m < 3; m += 2) begin
      apb(1'b1, A_C1, {1'b1, 2'(m), 5'h03});
      #1;
      chk(active, 1'b0);
    end
    for (int i = 0; i < 8; i++) convert(4'(i * 5), tcode[i], tcyc[i]);
    convert(4'h6, 3'h0, 39);
    apb(1'b1, A_C1, 8'ha6);
    wait_irq();
    apb(1'b1, A_C1, 8'ha9);
    apb(1'b0, A_RL, 8'h00);
    chk(r & 8'hf0, {code_lo(4'h6), 2'b01, 4'h0});
    apb(1'b0, A_RH, 8'h00);
    chk(r, code_hi(4'h6));
    wait_irq();
    apb(1'b1, A_C1, 8'hec);
    wait_irq();
    wait_irq();
    chk(16'(n), 16'h0027);
    chk(active, 1'b1);
    repeat (10) @(posedge clk);
    apb(1'b1, A_C1, 8'h0c);
    #1;
    chk(active, 1'b0);
    quiet(60);
    apb(1'b0, A_RH, 8'h00);
    chk(r, code_hi(4'hc));
    apb(1'b1, A_C2, 8'h30);
    #1;
    chk(ladder_on, 1'b1);
    apb(1'b1, A_C1, 8'ha7);
    repeat (10) @(posedge clk);
    low_power <= 1'b1;
    @(posedge clk);
    #1;
    chk(active, 1'b0);
    apb(1'b1, A_C1, 8'ha5);
    apb(1'b0, A_C1, 8'h00);
    chk(r, 8'h10);
    apb(1'b0, A_C2, 8'h00);
    chk(r & 8'h3f, 8'h10);
    apb(1'b0, A_RH, 8'h00);
    chk(r, 8'h00);
    @(posedge clk);
    low_power <= 1'b0;
    quiet(60);
    give_verdict();
  end
endmodule : sar_adc_sequencer_tb_top
`default_nettype wire
